// ### src/emap_port.sv
`timescale 1ns/100ps
`include "emap_regs.svh"
module emap_port
  import emap_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       clkEn,
  input  wire logic       extAccessN,
  input  wire emap_sel_t  extSel,
  input  wire emap_addr_t extAddrIn,
  input  wire emap_data_t extDataIn,
  input  wire logic       extWrN,
  output logic            extDataOe,
  output emap_data_t      extDataOut,
  output emap_addr_t      extAddrOut,
  output logic            coreClkEn,
  output logic            coreDrvOe,
  input  wire emap_addr_t coreAddr [3],
  input  wire emap_data_t coreWData [3],
  input  wire logic       coreWr [3],
  input  wire emap_data_t memRData [3],
  output emap_addr_t      memAddr [3],
  output emap_data_t      memWData [3],
  output logic            memWr [3]
);
  logic       accS1_q;
  logic       accS2_q;
  emap_sel_t  selS1_q;
  emap_sel_t  selS2_q;
  logic       acc_q;
  emap_addr_t snoopAddr_q;
  emap_data_t snoopData_q;

  // Access and select pins pass two flops before use; memories themselves stay asynchronous to the host
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      accS1_q <= 1'b0;
      accS2_q <= 1'b0;
      selS1_q <= `EMAP_SEL_NONE;
      selS2_q <= `EMAP_SEL_NONE;
    end else if (clkEn) begin
      accS1_q <= ~extAccessN;
      accS2_q <= accS1_q;
      selS1_q <= extSel;
      selS2_q <= selS1_q;
    end
  end

  function automatic logic selHit(input emap_sel_t s, input int i);
    selHit = (s != `EMAP_SEL_NONE) && (s == emap_sel_t'(i));
  endfunction

  // Registered mode flag: core clock enable toggles only on sys_clk edges, so no glitch
  always_ff @(posedge sys_clk) begin
    if (srst)
      acc_q <= 1'b0;
    else if (clkEn)
      acc_q <= accS2_q;
  end

  assign coreClkEn = ~acc_q;
  assign coreDrvOe = ~acc_q;
  // Bus driven by us only when snooping, never contending with the host
  assign extDataOe = ~acc_q;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gMem
      wire hit = selHit(selS2_q, g);
      assign memAddr[g]  = acc_q ? extAddrIn : coreAddr[g];
      assign memWData[g] = acc_q ? extDataIn : coreWData[g];
      assign memWr[g]    = acc_q ? (hit & ~extWrN) : coreWr[g];
    end
  endgenerate

  wire selOk = (selS2_q != `EMAP_SEL_NONE);
  wire [1:0] idx = selOk ? selS2_q : 2'h0;
  wire emap_data_t readData = acc_q ? memRData[idx] :
                              (coreWr[idx] ? coreWData[idx] : memRData[idx]);

  // Snoop mirror only reads core signals and memory read data, so core traffic is unaffected
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      snoopAddr_q <= '0;
      snoopData_q <= '0;
    end else if (clkEn) begin
      snoopAddr_q <= (selOk && !acc_q) ? coreAddr[idx] : '0;
      snoopData_q <= selOk ? readData : '0;
    end
  end
  assign extAddrOut = snoopAddr_q;
  assign extDataOut = snoopData_q;


  // Mode control: entry, exit and reset state

  core_halt_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && accS2_q |=> !coreClkEn)
    else $error("core clock not stopped in access mode");

  tri_state_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q |-> !coreDrvOe && !extDataOe)
    else $error("drivers enabled during access");

  oe_align_a: assert property (@(posedge sys_clk) disable iff (srst)
    coreDrvOe == coreClkEn && extDataOe == coreClkEn)
    else $error("mode outputs disagree");

  release_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && acc_q && !accS2_q |=> coreClkEn && coreDrvOe)
    else $error("core not released");

  run_stay_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && !accS2_q |=> coreClkEn)
    else $error("core halted without access request");

  // No disable here: the check is about what reset itself leaves behind
  reset_idle_a: assert property (@(posedge sys_clk)
    srst |=> coreClkEn && coreDrvOe && extDataOe && extAddrOut == '0 && extDataOut == '0)
    else $error("outputs not idle after reset");

  freeze_a: assert property (@(posedge sys_clk) disable iff (srst)
    !clkEn |=> $stable(acc_q) && $stable(extAddrOut) && $stable(extDataOut))
    else $error("state moved while frozen");

  // Host side of the memories in access mode

  one_mem_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q |-> $countones({memWr[0], memWr[1], memWr[2]}) <= 1)
    else $error("more than one memory written");

  host_x_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q && !extWrN && selS2_q == `EMAP_SEL_X |-> memWr[0] && !memWr[1] && !memWr[2])
    else $error("host write missed X memory");

  host_y_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q && !extWrN && selS2_q == `EMAP_SEL_Y |-> !memWr[0] && memWr[1] && !memWr[2])
    else $error("host write missed Y memory");

  host_p_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q && !extWrN && selS2_q == `EMAP_SEL_P |-> !memWr[0] && !memWr[1] && memWr[2])
    else $error("host write missed program memory");

  none_sel_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q && selS2_q == `EMAP_SEL_NONE |-> !memWr[0] && !memWr[1] && !memWr[2])
    else $error("unselected code wrote memory");

  host_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q && extWrN |-> !memWr[0] && !memWr[1] && !memWr[2])
    else $error("memory written without host strobe");

  mem_owner_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q |-> memAddr[0] == extAddrIn && memAddr[2] == extAddrIn)
    else $error("memory not owned by external bus");

  owner_y_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q |-> memAddr[1] == extAddrIn)
    else $error("Y memory not owned by external bus");

  host_data_a: assert property (@(posedge sys_clk) disable iff (srst)
    acc_q |-> memWData[0] == extDataIn && memWData[1] == extDataIn && memWData[2] == extDataIn)
    else $error("host data not routed to memories");

  // Run mode: core owns the memories, host only watches

  run_hostwr_a: assert property (@(posedge sys_clk) disable iff (srst)
    !acc_q && !extWrN |-> memWr[0] == coreWr[0] && memWr[1] == coreWr[1] && memWr[2] == coreWr[2])
    else $error("host strobe reached memory in run mode");

  core_own_a: assert property (@(posedge sys_clk) disable iff (srst)
    !acc_q |-> memAddr[0] == coreAddr[0] && memWr[0] == coreWr[0] && memWData[0] == coreWData[0])
    else $error("X memory not returned to core");

  core_own_p_a: assert property (@(posedge sys_clk) disable iff (srst)
    !acc_q |-> memAddr[2] == coreAddr[2] && memWr[2] == coreWr[2] && memWData[2] == coreWData[2])
    else $error("program memory not returned to core");

  snoop_free_a: assert property (@(posedge sys_clk) disable iff (srst)
    !acc_q |-> memWr[1] == coreWr[1] && memAddr[1] == coreAddr[1])
    else $error("snoop disturbed core access");

  snoop_oe_a: assert property (@(posedge sys_clk) disable iff (srst)
    !acc_q |-> extDataOe)
    else $error("snoop bus not driven in run mode");

  // Snoop mirror contents

  snoop_x_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && !acc_q && selS2_q == `EMAP_SEL_X |=> extAddrOut == $past(coreAddr[0]))
    else $error("snoop mirror wrong bus for X");

  snoop_mux_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && !acc_q && selS2_q == `EMAP_SEL_Y |=> extAddrOut == $past(coreAddr[1]))
    else $error("snoop mirror wrong bus");

  snoop_p_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && !acc_q && selS2_q == `EMAP_SEL_P |=> extAddrOut == $past(coreAddr[2]))
    else $error("snoop mirror wrong bus for program");

  addr_blank_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && (acc_q || selS2_q == `EMAP_SEL_NONE) |=> extAddrOut == '0)
    else $error("snoop address not blanked");

  data_blank_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && !selOk |=> extDataOut == '0)
    else $error("snoop data not blanked");

  snoop_wdata_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && !acc_q && selOk && coreWr[idx] |=> extDataOut == $past(coreWData[idx]))
    else $error("snoop missed core write data");

  snoop_rdata_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && !acc_q && selOk && !coreWr[idx] |=> extDataOut == $past(memRData[idx]))
    else $error("snoop missed memory read data");

  // Selection may move freely while the core runs

  sel_run_a: assert property (@(posedge sys_clk) disable iff (srst)
    clkEn && !accS2_q && !acc_q && $changed(selS2_q) |=> coreClkEn)
    else $error("select change halted core");
endmodule

// ### src/emap_regs.svh
`ifndef EMAP_REGS_SVH
`define EMAP_REGS_SVH
`define EMAP_SEL_X    2'h0
`define EMAP_SEL_Y    2'h1
`define EMAP_SEL_P    2'h2
`define EMAP_SEL_NONE 2'h3
`define EMAP_AW       16
`define EMAP_DW       24
`endif

// ### src/emap_pkg.sv
`include "emap_regs.svh"
package emap_pkg;
  typedef logic [1:0]           emap_sel_t;
  typedef logic [`EMAP_AW-1:0]  emap_addr_t;
  typedef logic [`EMAP_DW-1:0]  emap_data_t;
endpackage

// ### bench/emap_mem_model.sv
`timescale 1ns/100ps
module emap_mem_model
  import emap_pkg::*;
(
  input  wire emap_addr_t memAddr [3],
  input  wire emap_data_t memWData [3],
  input  wire logic       memWr [3],
  output emap_data_t      memRData [3]
);
  emap_data_t store [3][64];
  for (genvar i = 0; i < 3; i++) begin : g_mem
    // Asynchronous part: no clock, write lands at end of strobe
    always @(negedge memWr[i]) store[i][memAddr[i][5:0]] = memWData[i];
    // Read lines are not valid while writing, so show a changing value
    assign memRData[i] = memWr[i] ? ~memWData[i] : store[i][memAddr[i][5:0]];
  end
endmodule

// ### bench/tb_emap_port.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %h expected %h", $time, a, e); end end
module tb_emap_port;
  import emap_pkg::*;
  logic       sys_clk = 0, srst = 1, extAccessN = 1, extWrN = 1, clkEn = 1;
  logic       extDataOe, coreClkEn, coreDrvOe, coreWr [3], memWr [3];
  emap_sel_t  extSel = 2'h3;
  emap_addr_t extAddrIn = '0, extAddrOut, coreAddr [3], memAddr [3];
  emap_data_t extDataIn = '0, extDataOut, coreWData [3], memRData [3], memWData [3];
  logic [23:0] expQ [$], d;
  logic [15:0] a;
  int         kindQ [$], n_mismatch = 0, n_checks = 0, kk;
  logic [23:0] ev;
  event       look;
  emap_port emap_port_i (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
    .extAccessN(extAccessN), .extSel(extSel), .extAddrIn(extAddrIn), .extDataIn(extDataIn),
    .extWrN(extWrN), .extDataOe(extDataOe), .extDataOut(extDataOut), .extAddrOut(extAddrOut),
    .coreClkEn(coreClkEn), .coreDrvOe(coreDrvOe), .coreAddr(coreAddr), .coreWData(coreWData),
    .coreWr(coreWr), .memRData(memRData), .memAddr(memAddr), .memWData(memWData), .memWr(memWr));
  emap_mem_model emap_mem_model_i (.memAddr(memAddr), .memWData(memWData), .memWr(memWr),
    .memRData(memRData));
  initial forever #20 sys_clk = ~sys_clk;
  function automatic logic [23:0] obs(int k);
    case (k)
      0: return extDataOut;
      1: return {8'h00, extAddrOut};
      2: return {21'h000000, coreClkEn, coreDrvOe, extDataOe};
      3: return memWData[extSel];
      default: return {21'h000000, memWr[0], memWr[1], memWr[2]};
    endcase
  endfunction
  task automatic note(int k, logic [23:0] v);
    kindQ.push_back(k);
    expQ.push_back(v);
  endtask
  // Pop first: the compare macro names its arguments twice
  always @(look) begin
    while (expQ.size() > 0) begin
      kk = kindQ.pop_front();
      ev = expQ.pop_front();
      `CHK(obs(kk), ev)
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic waitOe(logic v);
    for (int i = 0; i < 20 && extDataOe !== v; i++) @(negedge sys_clk);
    if (extDataOe !== v) begin n_mismatch++; summarize(); end
  endtask
  initial begin
    for (int k = 0; k < 3; k++) begin coreAddr[k] = '0; coreWData[k] = '0; coreWr[k] = 0; end
    void'($urandom(29));
    repeat (12) @(posedge sys_clk);
    srst <= 0;
    for (int s = 0; s < 4; s++) begin
      @(posedge sys_clk);
      d = $urandom;
      a = $urandom;
      extSel <= s[1:0];
      for (int k = 0; k < 3; k++) coreWr[k] <= (k == s);
      if (s < 3) begin coreWData[s] <= d; coreAddr[s] <= a; end
      repeat (5) @(posedge sys_clk);
      #1 note(0, s < 3 ? d : 24'h000000);
      note(1, s < 3 ? {8'h00, a} : 24'h000000);
      note(2, 24'h000007);
      -> look;
    end
    @(posedge sys_clk);
    d = $urandom;
    clkEn <= 0;
    extSel <= 2'h0;
    coreWr[0] <= 1;
    coreWData[0] <= d;
    repeat (5) @(posedge sys_clk);
    #1 note(0, 24'h000000);
    -> look;
    @(posedge sys_clk) clkEn <= 1;
    repeat (4) @(posedge sys_clk);
    #1 note(0, d);
    -> look;
    @(posedge sys_clk) extAccessN <= 0;
    waitOe(0);
    #1 note(2, 24'h000000);
    for (int s = 0; s < 3; s++) begin
      @(posedge sys_clk);
      d = $urandom;
      extSel <= s[1:0];
      extDataIn <= d;
      a = $urandom;
      extAddrIn <= a;
      repeat (3) @(posedge sys_clk);
      extWrN <= 0;
      @(posedge sys_clk) #1 note(3, d);
      note(4, 24'h000004 >> s);
      -> look;
      @(posedge sys_clk) extWrN <= 1;
      repeat (2) @(posedge sys_clk);
      #1 note(0, d);
      note(1, 24'h000000);
      -> look;
    end
    @(posedge sys_clk) extAccessN <= 1;
    waitOe(1);
    #1 note(2, 24'h000007);
    note(3, coreWData[2]);
    -> look;
    #1 summarize();
  end
endmodule
